// >>> rtl/quadrature_event_counter.sv
// Purpose: Three 16-bit up/down counters fed by two-phase encoder inputs
// Assumes: APB slave with zero wait states; pins are asynchronous
// Notes: Index 0..2 are counter channels 2..4
// Summary of operation
// R01: Two-phase pins are the only count source, inputs
// R02: Reload type reloads on overflow or underflow, continues
// R03: Free-run type keeps counting without any reload
// R04: Up from n overflows after FFFF-n+1 events
// R05: Down from n underflows after n+1 events
// R06: Writing run bit 1 starts counting
// R07: Writing run bit 0 stops counting
// R08: Overflow or underflow raises the channel request
// R09: Reading counter register returns current count
// R10: Stopped or before first event: write loads both
// R11: After first event, write updates reload only
// R12: Normal: count phase-in edges while phase-out high
// R13: Times-four: in rising with out high counts up
// R14: Times-four: in falling with out high counts down
// R15: Channel 3 optional clear to zero by Z-phase
// R16: Method selectable on channel 3 only; others fixed
// R17: Method bit 0 normal, 1 times-four
// R18: Software sets two-phase enable before use
// R19: Software writes zero and sets Z enable first
// R20: Z-phase clear happens at the next count event
// R21: Inputs synchronised, one event per transition
`timescale 1ns/1ns
`default_nettype none
module quadrature_event_counter
  import qec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder pins, all inputs
  input wire logic [NUM_CH-1:0] phase_in_pin,
  input wire logic [NUM_CH-1:0] phase_out_pin,
  input wire logic z_phase_input_pin,
  // Per-channel overflow or underflow request
  output logic [NUM_CH-1:0] irq_request
);

  logic [NUM_CH-1:0] channel_run_bit;
  logic [NUM_CH-1:0] next_channel_run_bit;
  logic [NUM_CH-1:0] two_phase_enable_bit;
  logic [NUM_CH-1:0] next_two_phase_enable_bit;
  logic [NUM_CH-1:0] reload_or_freerun_select;
  logic [NUM_CH-1:0] next_reload_or_freerun_select;
  method_t processing_method_select;
  method_t next_processing_method_select;
  logic z_phase_clear_enable;
  logic next_z_phase_clear_enable;
  logic z_pol_rise;
  logic next_z_pol_rise;
  logic z_pending;
  logic next_z_pending;
  logic [NUM_CH-1:0] started;
  logic [NUM_CH-1:0] next_started;
  logic [NUM_CH-1:0] next_irq_request;
  logic [CNT_W-1:0] cnt [NUM_CH];
  logic [CNT_W-1:0] next_cnt [NUM_CH];
  logic [CNT_W-1:0] counter_reload_register [NUM_CH];
  logic [CNT_W-1:0] next_counter_reload_register [NUM_CH];
  logic [31:0] next_prdata;
  logic next_pslverr;

  logic [NUM_CH-1:0] in_level;
  logic [NUM_CH-1:0] in_rise;
  logic [NUM_CH-1:0] in_fall;
  logic [NUM_CH-1:0] out_level;
  logic [NUM_CH-1:0] out_rise;
  logic [NUM_CH-1:0] out_fall;
  logic [NUM_CH-1:0] ch_x4;
  logic [NUM_CH-1:0] ev_up;
  logic [NUM_CH-1:0] ev_down;
  logic [NUM_CH-1:0] ev;
  logic z_rise;
  logic z_fall;
  logic apb_wr;
  logic apb_setup;
  logic start_wr;

  function automatic logic [7:0] cnt_addr(input int unsigned idx);
    cnt_addr = ADDR_CNT_BASE + 8'(idx * 4);
  endfunction : cnt_addr

  assign apb_wr = psel & penable & pwrite;
  assign apb_setup = psel & ~penable;
  assign start_wr = apb_wr && paddr == ADDR_START;
  assign pready = 1'b1;

  pin_sync u_z_sync (
    .clk(clk),
    .nrst(nrst),
    .pin(z_phase_input_pin),
    .level(),
    .rise(z_rise),
    .fall(z_fall)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic z_clear;

      // Both encoder pins are sampled only, never driven
      pin_sync u_in_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(phase_in_pin[gi]),
        .level(in_level[gi]),
        .rise(in_rise[gi]),
        .fall(in_fall[gi])
      ); // [R01] [R21]

      pin_sync u_out_sync (
        .clk(clk),
        .nrst(nrst),
        .pin(phase_out_pin[gi]),
        .level(out_level[gi]),
        .rise(out_rise[gi]),
        .fall(out_fall[gi])
      ); // [R01] [R21]

      if (gi == CH_NORMAL) begin : g_fix_n
        assign ch_x4[gi] = 1'b0; // [R16]
      end else if (gi == CH_X4) begin : g_fix_x4
        assign ch_x4[gi] = 1'b1; // [R16]
      end else begin : g_sel
        assign ch_x4[gi] = (processing_method_select == METHOD_X4); // [R16] [R17]
      end

      quad_decoder u_dec (
        .x4(ch_x4[gi]),
        .in_level(in_level[gi]),
        .in_rise(in_rise[gi]),
        .in_fall(in_fall[gi]),
        .out_level(out_level[gi]),
        .out_rise(out_rise[gi]),
        .out_fall(out_fall[gi]),
        .up(ev_up[gi]),
        .down(ev_down[gi])
      );

      // Count only while running with two-phase processing enabled
      assign ev[gi] = channel_run_bit[gi] & two_phase_enable_bit[gi] &
                      (ev_up[gi] | ev_down[gi]); // [R06] [R07] [R18]
      assign z_clear = (gi == CH_SELECT) && z_pending;

      always_comb begin
        next_cnt[gi] = cnt[gi];
        next_counter_reload_register[gi] = counter_reload_register[gi];
        next_started[gi] = started[gi];
        next_irq_request[gi] = 1'b0;
        if (ev[gi]) begin
          next_started[gi] = 1'b1;
          if (z_clear) begin
            next_cnt[gi] = CNT_ZERO; // [R15] [R20]
          end else if (ev_up[gi]) begin
            if (cnt[gi] == CNT_MAX) begin
              next_irq_request[gi] = 1'b1; // [R08] [R04]
              next_cnt[gi] = reload_or_freerun_select[gi] ? CNT_ZERO :
                             counter_reload_register[gi]; // [R02] [R03]
            end else begin
              next_cnt[gi] = cnt[gi] + 16'h0001;
            end
          end else begin
            if (cnt[gi] == CNT_ZERO) begin
              next_irq_request[gi] = 1'b1; // [R08] [R05]
              next_cnt[gi] = reload_or_freerun_select[gi] ? CNT_MAX :
                             counter_reload_register[gi]; // [R02] [R03]
            end else begin
              next_cnt[gi] = cnt[gi] - 16'h0001;
            end
          end
        end
        if (apb_wr && paddr == cnt_addr(gi)) begin
          next_counter_reload_register[gi] = pwdata[CNT_W-1:0]; // [R11]
          if (!channel_run_bit[gi] || !started[gi]) begin
            next_cnt[gi] = pwdata[CNT_W-1:0]; // [R10]
          end
        end
        // A fresh start waits again for its first count event
        if (start_wr && pwdata[gi] && !channel_run_bit[gi]) begin
          next_started[gi] = 1'b0; // [R10]
        end
      end

      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          cnt[gi] <= CNT_RESET;
          counter_reload_register[gi] <= CNT_RESET;
          started[gi] <= 1'b0;
          irq_request[gi] <= 1'b0;
        end else begin
          cnt[gi] <= next_cnt[gi];
          counter_reload_register[gi] <= next_counter_reload_register[gi];
          started[gi] <= next_started[gi];
          irq_request[gi] <= next_irq_request[gi];
        end
      end
    end
  endgenerate

  // Control registers, Z-phase capture and APB read path
  always_comb begin
    next_channel_run_bit = channel_run_bit;
    next_two_phase_enable_bit = two_phase_enable_bit;
    next_reload_or_freerun_select = reload_or_freerun_select;
    next_processing_method_select = processing_method_select;
    next_z_phase_clear_enable = z_phase_clear_enable;
    next_z_pol_rise = z_pol_rise;
    next_z_pending = z_pending;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (start_wr) begin
      next_channel_run_bit = pwdata[NUM_CH-1:0]; // [R06] [R07]
    end
    if (apb_wr && paddr == ADDR_UPDN) begin
      next_two_phase_enable_bit = pwdata[NUM_CH-1:0];
    end
    if (apb_wr && paddr == ADDR_MODE) begin
      next_reload_or_freerun_select = pwdata[MODE_FREERUN_LSB +: NUM_CH];
      next_processing_method_select = method_t'(pwdata[MODE_METHOD_BIT]); // [R17]
    end
    if (apb_wr && paddr == ADDR_ZCTL) begin
      next_z_phase_clear_enable = pwdata[ZCTL_EN_BIT];
      next_z_pol_rise = pwdata[ZCTL_POL_BIT];
    end
    // Pending Z clear is consumed by the next count event; a new edge wins
    if (ev[CH_SELECT]) begin
      next_z_pending = 1'b0; // [R20]
    end
    if (z_phase_clear_enable && (z_pol_rise ? z_rise : z_fall)) begin
      next_z_pending = 1'b1; // [R15] [R20]
    end
    if (!z_phase_clear_enable) begin
      next_z_pending = 1'b0;
    end
    if (apb_setup) begin
      next_prdata = RDATA_RESET;
      next_pslverr = 1'b0;
      if (!pwrite) begin
        case (paddr)
          ADDR_START: next_prdata = 32'(channel_run_bit);
          ADDR_UPDN: next_prdata = 32'(two_phase_enable_bit);
          ADDR_MODE: begin
            next_prdata[MODE_FREERUN_LSB +: NUM_CH] = reload_or_freerun_select;
            next_prdata[MODE_METHOD_BIT] = processing_method_select;
          end
          ADDR_ZCTL: begin
            next_prdata[ZCTL_EN_BIT] = z_phase_clear_enable;
            next_prdata[ZCTL_POL_BIT] = z_pol_rise;
          end
          ADDR_STATUS: begin
            next_prdata[NUM_CH-1:0] = started;
            next_prdata[STATUS_ZPEND_BIT] = z_pending;
          end
          default: next_pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          ADDR_START, ADDR_UPDN, ADDR_MODE, ADDR_ZCTL, ADDR_STATUS: next_pslverr = 1'b0;
          default: next_pslverr = 1'b1;
        endcase
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (paddr == cnt_addr(i)) begin
          next_pslverr = 1'b0;
          if (!pwrite) begin
            next_prdata = 32'(cnt[i]); // [R09]
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      channel_run_bit <= CH_BITS_RESET;
      two_phase_enable_bit <= CH_BITS_RESET;
      reload_or_freerun_select <= CH_BITS_RESET;
      processing_method_select <= METHOD_NORMAL;
      z_phase_clear_enable <= 1'b0;
      z_pol_rise <= 1'b0;
      z_pending <= 1'b0;
      prdata <= RDATA_RESET;
      pslverr <= 1'b0;
    end else begin
      channel_run_bit <= next_channel_run_bit;
      two_phase_enable_bit <= next_two_phase_enable_bit;
      reload_or_freerun_select <= next_reload_or_freerun_select;
      processing_method_select <= next_processing_method_select;
      z_phase_clear_enable <= next_z_phase_clear_enable;
      z_pol_rise <= next_z_pol_rise;
      z_pending <= next_z_pending;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : quadrature_event_counter
`default_nettype wire

// >>> rtl/qec_pkg.sv
// Purpose: Shared constants for the two-phase event counter block
// Assumes: APB register map with one aligned 32-bit word per register
// Notes: Channel index 0..2 stands for counter channels 2..4
package qec_pkg;

  localparam int NUM_CH = 3;
  localparam int CNT_W = 16;

  // Channel indices
  localparam int CH_NORMAL = 0;
  localparam int CH_SELECT = 1;
  localparam int CH_X4 = 2;

  // Register byte addresses
  localparam logic [7:0] ADDR_START = 8'h00;
  localparam logic [7:0] ADDR_UPDN = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_ZCTL = 8'h0C;
  localparam logic [7:0] ADDR_CNT_BASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // Field positions
  localparam int MODE_FREERUN_LSB = 0;
  localparam int MODE_METHOD_BIT = 3;
  localparam int ZCTL_EN_BIT = 0;
  localparam int ZCTL_POL_BIT = 1;
  localparam int STATUS_ZPEND_BIT = 3;

  // Values after reset and counter limits
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [NUM_CH-1:0] CH_BITS_RESET = 3'h0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic {
    METHOD_NORMAL = 1'b0,
    METHOD_X4 = 1'b1
  } method_t;

endpackage : qec_pkg

// >>> rtl/pin_sync.sv
// Purpose: Bring one pin into the clock domain and report its edges
// Assumes: Pin is asynchronous to clk
// Notes: Level changes only once the second and third stages agree
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin
  input wire logic pin,
  // Filtered level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic s1;
  logic s2;
  logic s3;
  logic next_level;
  logic next_rise;
  logic next_fall;

  always_comb begin
    next_level = level;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if (s2 == s3 && s3 != level) begin
      next_level = s3;
      next_rise = s3;
      next_fall = ~s3;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

endmodule : pin_sync
`default_nettype wire

// >>> rtl/quad_decoder.sv
// Purpose: Turn synchronised phase edges into up and down count events
// Assumes: Levels already show the value after any edge flagged this cycle
// Notes: In times-four, edges on both pins in one cycle are dropped as ambiguous
`timescale 1ns/1ns
`default_nettype none
module quad_decoder (
  // Processing method
  input wire logic x4,
  // Phase-in pin state
  input wire logic in_level,
  input wire logic in_rise,
  input wire logic in_fall,
  // Phase-out pin state
  input wire logic out_level,
  input wire logic out_rise,
  input wire logic out_fall,
  // Count events
  output logic up,
  output logic down
);

  logic both;

  always_comb begin
    both = (in_rise | in_fall) & (out_rise | out_fall);
    if (!x4) begin
      up = in_rise & out_level; // [R12]
      down = in_fall & out_level; // [R12]
    end else begin
      // Direction follows the phase order: out leading in counts up
      up = ~both & ((in_rise & out_level) | (in_fall & ~out_level) |
                    (out_rise & ~in_level) | (out_fall & in_level)); // [R13]
      down = ~both & ((in_rise & ~out_level) | (in_fall & out_level) |
                      (out_rise & in_level) | (out_fall & ~in_level)); // [R14]
    end
  end

endmodule : quad_decoder
`default_nettype wire

// >>> dv/qec_props.sv
// Purpose: Port-level assertions for the two-phase event counter
// Assumes: Zero-wait APB; encoder transitions at least two clocks apart
// Notes: Bound to the design top after the module
`timescale 1ns/1ns
`default_nettype none
module qec_props
  import qec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Encoder and requests
  input wire logic [NUM_CH-1:0] phase_in_pin,
  input wire logic [NUM_CH-1:0] phase_out_pin,
  input wire logic z_phase_input_pin,
  input wire logic [NUM_CH-1:0] irq_request
);
  logic [NUM_CH-1:0] run_sh, en_sh, next_run_sh, next_en_sh;
  logic wr_acc;
  logic [1:0] x4_pins;
  assign x4_pins = {phase_in_pin[CH_X4], phase_out_pin[CH_X4]};
  // Shadow copies of run and two-phase enable bits
  always_comb begin
    wr_acc = psel && penable && pwrite && pready;
    next_run_sh = (wr_acc && paddr == ADDR_START) ? pwdata[NUM_CH-1:0] : run_sh;
    next_en_sh = (wr_acc && paddr == ADDR_UPDN) ? pwdata[NUM_CH-1:0] : en_sh;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_sh <= CH_BITS_RESET;
      en_sh <= CH_BITS_RESET;
    end else begin
      run_sh <= next_run_sh;
      en_sh <= next_en_sh;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_bad_xfer;
    psel && !penable && paddr > ADDR_STATUS ##1 psel && penable;
  endsequence
  sequence s_good_setup;
    psel && !penable && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0;
  endsequence
  AST_UNMAPPED: assert property (s_bad_xfer |-> pslverr && prdata == RDATA_RESET)
    else $error("unmapped access not refused");
  AST_MAPPED_OK: assert property (s_good_setup |=> !pslverr)
    else $error("mapped access refused");
  AST_RUN_RESV: assert property (psel && !penable && paddr == ADDR_START |=>
    prdata[31:NUM_CH] == 29'h0) else $error("run register upper bits set");
  AST_PRDATA_HOLD: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  AST_IRQ_PULSE: assert property (|irq_request |=> (irq_request & $past(irq_request)) == 3'h0)
    else $error("request longer than one cycle");
  AST_IRQ_RUN: assert property ((irq_request &
    ~((run_sh | $past(run_sh)) & (en_sh | $past(en_sh)))) == 3'h0)
    else $error("request from idle channel");
  AST_CH2_SRC: assert property (irq_request[CH_NORMAL] |->
    $past(phase_in_pin[CH_NORMAL], 4) != $past(phase_in_pin[CH_NORMAL], 5) ||
    $past(phase_in_pin[CH_NORMAL], 5) != $past(phase_in_pin[CH_NORMAL], 6))
    else $error("channel 2 request without phase-in edge");
  AST_CH4_SRC: assert property (irq_request[CH_X4] |->
    $past(x4_pins, 4) != $past(x4_pins, 5) || $past(x4_pins, 5) != $past(x4_pins, 6))
    else $error("channel 4 request without pin edge");
endmodule : qec_props
bind quadrature_event_counter qec_props i_qec_props (
  .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phase_in_pin(phase_in_pin), .phase_out_pin(phase_out_pin),
  .z_phase_input_pin(z_phase_input_pin), .irq_request(irq_request)
);
`default_nettype wire

// >>> dv/encoder_model.sv
// Purpose: Incremental encoder with index pulse for all three channels
// Assumes: Steps spaced well beyond the input synchroniser depth
// Notes: Up means out leads, so in rises while out is high
`timescale 1ns/1ns
`default_nettype none
module encoder_model
  import qec_pkg::*;
(
  // Clock
  input wire logic clk,
  // Encoder outputs
  output logic [NUM_CH-1:0] phase_in_pin,
  output logic [NUM_CH-1:0] phase_out_pin,
  output logic z_phase_input_pin
);
  localparam int GAP = 8;
  logic [1:0] pos [NUM_CH];
  initial begin
    foreach (pos[k]) pos[k] = 2'h0;
    z_phase_input_pin = 1'b0;
  end
  // Gray sequence 00, 01, 11, 10 as (in, out)
  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      phase_in_pin[k] = pos[k][1];
      phase_out_pin[k] = pos[k][1] ^ pos[k][0];
    end
  end
  task automatic step(input int ch, input logic up, input int n);
    repeat (n) begin
      @(posedge clk);
      pos[ch] <= up ? pos[ch] + 2'h1 : pos[ch] - 2'h1;
      repeat (GAP) @(posedge clk);
    end
  endtask : step
  task automatic zpulse();
    @(posedge clk);
    z_phase_input_pin <= 1'b1;
    repeat (GAP) @(posedge clk);
    z_phase_input_pin <= 1'b0;
    repeat (GAP) @(posedge clk);
  endtask : zpulse
endmodule : encoder_model
`default_nettype wire

// >>> dv/tb_top.sv
// Purpose: Register-level tests of the two-phase event counter
// Assumes: Zero-wait APB slave; encoder model paces every step
// Notes: Expected counts follow from the step sequences applied
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import qec_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr, z_phase_input_pin;
  logic [NUM_CH-1:0] phase_in_pin, phase_out_pin, irq_request;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int irq_cnt [NUM_CH] = '{0, 0, 0};
  always #50 clk = ~clk;
  quadrature_event_counter i_quadrature_event_counter (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_in_pin(phase_in_pin), .phase_out_pin(phase_out_pin),
    .z_phase_input_pin(z_phase_input_pin), .irq_request(irq_request)
  );
  encoder_model i_encoder_model (
    .clk(clk), .phase_in_pin(phase_in_pin), .phase_out_pin(phase_out_pin),
    .z_phase_input_pin(z_phase_input_pin)
  );
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cyc++;
    for (int k = 0; k < NUM_CH; k++) begin
      if (irq_request[k] === 1'b1) begin
        irq_cnt[k]++;
      end
    end
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : chk
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    rd(ADDR_CNT_BASE, 32'h0000_0000);
    apb(8'h20, 1'b0, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, rerr});
    apb(ADDR_UPDN, 1'b1, 32'h0000_0007);
    apb(ADDR_CNT_BASE, 1'b1, 32'h0000_FFFE);
    rd(ADDR_CNT_BASE, 32'h0000_FFFE);
    apb(ADDR_START, 1'b1, 32'h0000_0001);
    i_encoder_model.step(CH_NORMAL, 1'b1, 4);
    rd(ADDR_CNT_BASE, 32'h0000_FFFF);
    apb(ADDR_CNT_BASE, 1'b1, 32'h0000_1234);
    rd(ADDR_CNT_BASE, 32'h0000_FFFF);
    i_encoder_model.step(CH_NORMAL, 1'b1, 4);
    rd(ADDR_CNT_BASE, 32'h0000_1234);
    chk("irq ch2", 32'h0000_0001, irq_cnt[CH_NORMAL]);
    i_encoder_model.step(CH_NORMAL, 1'b0, 4);
    rd(ADDR_CNT_BASE, 32'h0000_1233);
    apb(ADDR_START, 1'b1, 32'h0000_0000);
    i_encoder_model.step(CH_NORMAL, 1'b1, 4);
    rd(ADDR_CNT_BASE, 32'h0000_1233);
    // Channel 4: free-run, always times-four
    apb(ADDR_MODE, 1'b1, 32'h0000_0004);
    apb(ADDR_CNT_BASE + 8'h08, 1'b1, 32'h0000_0001);
    apb(ADDR_START, 1'b1, 32'h0000_0004);
    i_encoder_model.step(CH_X4, 1'b0, 2);
    rd(ADDR_CNT_BASE + 8'h08, 32'h0000_FFFF);
    i_encoder_model.step(CH_X4, 1'b1, 1);
    rd(ADDR_CNT_BASE + 8'h08, 32'h0000_0000);
    chk("irq ch4", 32'h0000_0002, irq_cnt[CH_X4]);
    // Channel 3: method select, then index clear
    apb(ADDR_START, 1'b1, 32'h0000_0006);
    i_encoder_model.step(CH_SELECT, 1'b1, 4);
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0001);
    apb(ADDR_MODE, 1'b1, 32'h0000_000C);
    rd(ADDR_MODE, 32'h0000_000C);
    i_encoder_model.step(CH_SELECT, 1'b1, 4);
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0005);
    apb(ADDR_CNT_BASE + 8'h04, 1'b1, 32'h0000_0000);
    apb(ADDR_ZCTL, 1'b1, 32'h0000_0003);
    i_encoder_model.zpulse();
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0005);
    rd(ADDR_STATUS, 32'h0000_000F);
    i_encoder_model.step(CH_SELECT, 1'b1, 1);
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0000);
    i_encoder_model.step(CH_SELECT, 1'b1, 1);
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0001);
    // Falling Z edge selected, clear still waits for a count event
    apb(ADDR_ZCTL, 1'b1, 32'h0000_0001);
    i_encoder_model.zpulse();
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0001);
    i_encoder_model.step(CH_SELECT, 1'b1, 1);
    rd(ADDR_CNT_BASE + 8'h04, 32'h0000_0000);
    chk("irq ch3", 32'h0000_0000, irq_cnt[CH_SELECT]);
    // Channel 2 stays normal while the method bit asks for times-four
    apb(ADDR_START, 1'b1, 32'h0000_0007);
    i_encoder_model.step(CH_NORMAL, 1'b1, 4);
    rd(ADDR_CNT_BASE, 32'h0000_1234);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
